// >>> src/ecc2_consts.svh
`ifndef ECC2_CONSTS_SVH
`define ECC2_CONSTS_SVH
// register index and byte addresses (byte address = 4 * index)
`define ECC2_IDX_A_CTRL2 8'h01
`define ECC2_IDX_B_CTRL2 8'h21
`define ECC2_ADDR_A_CTRL2 8'h04
`define ECC2_ADDR_B_CTRL2 8'h84
`define ECC2_ADDR_CTRL1 8'h00
`define ECC2_ADDR_STATUS 8'h88
`define ECC2_ADDR_IRQ_STAT 8'h8c
`define ECC2_ADDR_IRQ_MASK 8'h90
`define ECC2_ADDR_B_PEND 8'h94
// field positions of control register two
`define ECC2_BIT_TONE_OFF 7
`define ECC2_BIT_PHASE_IGN 6
`define ECC2_BIT_NLP_OFF 5
`define ECC2_BIT_AUTO_BYP 4
`define ECC2_BIT_NB_OFF 3
`define ECC2_BIT_HPF_OFF 2
`define ECC2_BIT_MUTE_S 1
`define ECC2_BIT_MUTE_R 0
// control register one reset bit
`define ECC2_BIT_SOFT_RST 7
// reset values
`define ECC2_CTRL2_RESET 8'h00
// double write window
`define ECC2_B_MIN_NS 350
`define ECC2_B_MAX_NS 20000
`define ECC2_CLK_NS 40
`define ECC2_B_MIN_CYC ((`ECC2_B_MIN_NS + `ECC2_CLK_NS - 1) / `ECC2_CLK_NS)
`define ECC2_B_MAX_CYC (`ECC2_B_MAX_NS / `ECC2_CLK_NS)
// interrupt bit positions
`define ECC2_IRQ_TONE_A 0
`define ECC2_IRQ_TONE_B 1
`define ECC2_IRQ_B_BAD 2
`endif

// >>> src/ecc2_pkg.sv
package ecc2_pkg;
   // per canceller control register two fields
   typedef struct packed {
      logic tone_detect_off;
      logic phase_reversal_ignore;
      logic nonlinear_proc_off;
      logic auto_tone_bypass;
      logic narrowband_detect_off;
      logic offset_filter_off;
      logic send_out_silence;
      logic receive_out_silence;
   } ecc2_ctrl_t;
   // tone detector inputs per canceller
   typedef struct packed {
      logic tone_plain;
      logic tone_phase_rev;
   } ecc2_tone_t;
   // state of the canceller b double write sequence
   typedef enum logic [1:0] {
      ECC2_B_IDLE = 2'b00,
      ECC2_B_WAIT = 2'b01
   } ecc2_bstate_t;
endpackage : ecc2_pkg

// >>> src/ecc2_bwrite.sv
`timescale 1ns/1ps
`include "ecc2_consts.svh"
module ecc2_bwrite #(
   parameter int MAX_CYC = `ECC2_B_MAX_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic soft_clr,
   // write strobe and data
   input wire logic wr_stb,
   input wire logic [7:0] wr_data,
   // outcome
   output logic commit,
   output logic [7:0] commit_data,
   output logic bad,
   output logic pending
);
   localparam logic [15:0] MIN_C = 16'(`ECC2_B_MIN_CYC);
   localparam logic [15:0] MAX_C = 16'(MAX_CYC);
   ecc2_pkg::ecc2_bstate_t state_reg, state_next;
   logic [15:0] cnt_reg;
   logic [7:0] data_reg;
   wire in_win = (cnt_reg >= MIN_C) && (cnt_reg <= MAX_C);
   wire match = wr_stb && (state_reg == ecc2_pkg::ECC2_B_WAIT) && in_win && (wr_data == data_reg);
   wire timeout = (state_reg == ecc2_pkg::ECC2_B_WAIT) && (cnt_reg > MAX_C);
   wire early = wr_stb && (state_reg == ecc2_pkg::ECC2_B_WAIT) && !match;
   // next state of the sequence
   always_comb begin
      case (state_reg)
         ecc2_pkg::ECC2_B_IDLE: state_next = wr_stb ? ecc2_pkg::ECC2_B_WAIT : ecc2_pkg::ECC2_B_IDLE;
         ecc2_pkg::ECC2_B_WAIT: begin
            if (match || timeout) state_next = ecc2_pkg::ECC2_B_IDLE;
            else state_next = ecc2_pkg::ECC2_B_WAIT;
         end
         default: state_next = ecc2_pkg::ECC2_B_IDLE;
      endcase
   end
   // sequence registers; a mismatched second write restarts the window
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ecc2_pkg::ECC2_B_IDLE;
         cnt_reg <= 16'h0000;
         data_reg <= 8'h00;
         commit <= 1'b0;
         commit_data <= 8'h00;
         bad <= 1'b0;
         pending <= 1'b0;
      end else if (soft_clr) begin
         state_reg <= ecc2_pkg::ECC2_B_IDLE;
         cnt_reg <= 16'h0000;
         commit <= 1'b0;
         bad <= 1'b0;
         pending <= 1'b0;
      end else begin
         state_reg <= early ? ecc2_pkg::ECC2_B_WAIT : state_next;
         cnt_reg <= (wr_stb && !match) ? 16'h0001 : (cnt_reg + 16'h0001);
         if (wr_stb) data_reg <= wr_data;
         commit <= match;
         commit_data <= data_reg;
         bad <= early || timeout;
         pending <= early ? 1'b1 : ((state_next == ecc2_pkg::ECC2_B_WAIT) && !match);
      end
   end
   // a commit always comes from a matching second write inside the window
   commit_win_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      commit |-> $past(in_win) && $past(state_reg) == ecc2_pkg::ECC2_B_WAIT)
      else $error("canceller b commit outside double write window");
endmodule : ecc2_bwrite

// >>> src/ecc2_top.sv
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ecc2_consts.svh"
// Overview of operation
// - a set tone detect off bit stops that canceller's tone detection, a clear bit lets it run.
// - with both tone detect off bits set the group's tone disable processors power down.
// - with phase reversal ignore set any 2100 Hz tone triggers the detector.
// - with phase reversal ignore clear only a 2100 Hz tone with phase reversals triggers.
// - with offset filter off set the receive-in and send-in high pass filters are bypassed.
// - with offset filter off clear the offset nulling filters run and remove dc.
// - the gated tone flag is high only while auto tone bypass is on and a tone is detected.
// - the reset bit of control one presets the control registers, itself included, and clears coefficients; interrupt status and mask keep their values.
module ecc2_top #(
   parameter int B_MAX_CYC = `ECC2_B_MAX_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // axi4-lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // tone detector raw inputs from the signal path
   input wire logic [1:0] tone_plain_in,
   input wire logic [1:0] tone_rev_in,
   // per canceller and group controls to the datapath, coefficient clear and interrupt
   output logic [1:0] tone_detect_en,
   output logic tone_proc_power_down,
   output logic [1:0] tone_qualified,
   output logic [1:0] gated_tone_flag,
   output logic [1:0] echo_cancel_off,
   output logic [1:0] offset_filter_bypass,
   output logic [1:0] nonlinear_proc_off,
   output logic [1:0] narrowband_detect_off,
   output logic [1:0] send_out_silence,
   output logic [1:0] receive_out_silence,
   output logic coeff_clear,
   output logic irq
);
   // ********************************
   // bus slave
   // ********************************
   ecc2_pkg::ecc2_ctrl_t ctrl_reg [2];
   logic [7:0] ctrl1_reg;
   logic [2:0] irq_stat_reg, irq_mask_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic aw_have_reg, w_have_reg;
   logic [1:0] tone_s1_reg, tone_s2_reg, rev_s1_reg, rev_s2_reg;
   logic [1:0] tone_det;
   logic b_commit, b_bad, b_pending;
   logic [7:0] b_commit_data;
   wire do_wr = aw_have_reg && w_have_reg && !s_axi_bvalid;
   wire wr_lane0 = do_wr && w_strb_reg[0];
   wire [7:0] wb = w_data_reg[7:0];
   wire wr_ctrl1 = wr_lane0 && (aw_addr_reg == `ECC2_ADDR_CTRL1);
   wire soft_rst = wr_ctrl1 && wb[`ECC2_BIT_SOFT_RST];
   wire wr_a = wr_lane0 && (aw_addr_reg == `ECC2_ADDR_A_CTRL2);
   wire wr_b = wr_lane0 && (aw_addr_reg == `ECC2_ADDR_B_CTRL2);
   wire wr_istat = wr_lane0 && (aw_addr_reg == `ECC2_ADDR_IRQ_STAT);
   wire wr_imask = wr_lane0 && (aw_addr_reg == `ECC2_ADDR_IRQ_MASK);
   wire wr_hit = (aw_addr_reg == `ECC2_ADDR_CTRL1) || (aw_addr_reg == `ECC2_ADDR_A_CTRL2) ||
      (aw_addr_reg == `ECC2_ADDR_B_CTRL2) || (aw_addr_reg == `ECC2_ADDR_IRQ_STAT) ||
      (aw_addr_reg == `ECC2_ADDR_IRQ_MASK) || (aw_addr_reg == `ECC2_ADDR_STATUS) ||
      (aw_addr_reg == `ECC2_ADDR_B_PEND);
   // read decode
   wire [7:0] status_byte = {6'h00, gated_tone_flag};
   wire [7:0] rd_byte =
      (s_axi_araddr == `ECC2_ADDR_CTRL1) ? ctrl1_reg :
      (s_axi_araddr == `ECC2_ADDR_A_CTRL2) ? ctrl_reg[0] :
      (s_axi_araddr == `ECC2_ADDR_B_CTRL2) ? ctrl_reg[1] :
      (s_axi_araddr == `ECC2_ADDR_STATUS) ? status_byte :
      (s_axi_araddr == `ECC2_ADDR_IRQ_STAT) ? {5'h00, irq_stat_reg} :
      (s_axi_araddr == `ECC2_ADDR_IRQ_MASK) ? {5'h00, irq_mask_reg} :
      (s_axi_araddr == `ECC2_ADDR_B_PEND) ? {7'h00, b_pending} : 8'h00;
   wire rd_hit = (s_axi_araddr == `ECC2_ADDR_CTRL1) || (s_axi_araddr == `ECC2_ADDR_A_CTRL2) ||
      (s_axi_araddr == `ECC2_ADDR_B_CTRL2) || (s_axi_araddr == `ECC2_ADDR_STATUS) ||
      (s_axi_araddr == `ECC2_ADDR_IRQ_STAT) || (s_axi_araddr == `ECC2_ADDR_IRQ_MASK) ||
      (s_axi_araddr == `ECC2_ADDR_B_PEND);
   wire rd_take = s_axi_arvalid && s_axi_arready;

   // write channel capture
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready) && !do_wr;
         s_axi_wready <= !w_have_reg && !(s_axi_wvalid && s_axi_wready) && !do_wr;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (do_wr) aw_have_reg <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (do_wr) w_have_reg <= 1'b0;
      end
   end

   // write response and read answer
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else begin
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
         end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
         s_axi_arready <= !s_axi_rvalid && !rd_take;
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
         end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
      end
   end

   // ********************************
   // control registers
   // ********************************
   ecc2_bwrite #(
      .MAX_CYC(B_MAX_CYC)
   ) u_bwrite (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .soft_clr(soft_rst),
      .wr_stb(wr_b),
      .wr_data(wb),
      .commit(b_commit),
      .commit_data(b_commit_data),
      .bad(b_bad),
      .pending(b_pending)
   );

   // control one holds only its reset bit here, which clears itself
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl1_reg <= 8'h00;
         ctrl_reg[0] <= `ECC2_CTRL2_RESET;
         ctrl_reg[1] <= `ECC2_CTRL2_RESET;
         coeff_clear <= 1'b0;
      end else begin
         ctrl1_reg <= 8'h00;
         coeff_clear <= soft_rst;
         if (soft_rst) begin
            ctrl_reg[0] <= `ECC2_CTRL2_RESET;
            ctrl_reg[1] <= `ECC2_CTRL2_RESET;
         end else begin
            if (wr_a) ctrl_reg[0] <= wb;
            if (b_commit) ctrl_reg[1] <= b_commit_data;
         end
      end
   end

   // ********************************
   // tone path and datapath controls
   // ********************************
   // two flop synchronisers for the detector inputs
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tone_s1_reg <= 2'b00;
         tone_s2_reg <= 2'b00;
         rev_s1_reg <= 2'b00;
         rev_s2_reg <= 2'b00;
      end else begin
         tone_s1_reg <= tone_plain_in;
         tone_s2_reg <= tone_s1_reg;
         rev_s1_reg <= tone_rev_in;
         rev_s2_reg <= rev_s1_reg;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_canc
         // qualification: any tone or only phase reversed tone
         assign tone_det[g] = !ctrl_reg[g].tone_detect_off &&
            (ctrl_reg[g].phase_reversal_ignore ? tone_s2_reg[g] : rev_s2_reg[g]);
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               tone_detect_en[g] <= 1'b0;
               tone_qualified[g] <= 1'b0;
               gated_tone_flag[g] <= 1'b0;
               echo_cancel_off[g] <= 1'b0;
               offset_filter_bypass[g] <= 1'b0;
               nonlinear_proc_off[g] <= 1'b0;
               narrowband_detect_off[g] <= 1'b0;
               send_out_silence[g] <= 1'b0;
               receive_out_silence[g] <= 1'b0;
            end else begin
               tone_detect_en[g] <= !ctrl_reg[g].tone_detect_off;
               tone_qualified[g] <= tone_det[g];
               gated_tone_flag[g] <= ctrl_reg[g].auto_tone_bypass && tone_det[g];
               echo_cancel_off[g] <= ctrl_reg[g].auto_tone_bypass && tone_det[g];
               offset_filter_bypass[g] <= ctrl_reg[g].offset_filter_off;
               nonlinear_proc_off[g] <= ctrl_reg[g].nonlinear_proc_off;
               narrowband_detect_off[g] <= ctrl_reg[g].narrowband_detect_off;
               send_out_silence[g] <= ctrl_reg[g].send_out_silence;
               receive_out_silence[g] <= ctrl_reg[g].receive_out_silence;
            end
         end
         // the gated flag follows its cause one cycle later
         gated_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
            gated_tone_flag[g] == $past(ctrl_reg[g].auto_tone_bypass && tone_det[g]))
            else $error("gated tone flag does not match bypass and detection");
         // no tone reported while detection is off
         tone_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
            $past(ctrl_reg[g].tone_detect_off) |-> !tone_qualified[g] && !tone_detect_en[g])
            else $error("tone reported with detection off");
         // plain tone alone must not trigger without the ignore bit
         phase_need_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
            $past(!ctrl_reg[g].phase_reversal_ignore && !rev_s2_reg[g]) |-> !tone_qualified[g])
            else $error("tone qualified without phase reversal");
         // any tone triggers with the ignore bit
         phase_any_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
            $past(ctrl_reg[g].phase_reversal_ignore && !ctrl_reg[g].tone_detect_off && tone_s2_reg[g])
            |-> tone_qualified[g])
            else $error("tone missed with phase reversal ignored");
         // filter bypass follows its control bit
         hpf_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
            offset_filter_bypass[g] == $past(ctrl_reg[g].offset_filter_off))
            else $error("offset filter bypass wrong");
         // filter stays in the path while its off bit is clear
         hpf_active_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
            !$past(ctrl_reg[g].offset_filter_off) |-> !offset_filter_bypass[g])
            else $error("offset filter bypassed while enabled");
         // cancellation only stops on a gated tone
         cancel_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
            echo_cancel_off[g] |-> gated_tone_flag[g])
            else $error("cancellation off without gated tone");
      end
   endgenerate

   // group power down and interrupts: tone events and a failed b double write
   wire [2:0] irq_ev = {b_bad, gated_tone_flag[1], gated_tone_flag[0]};
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tone_proc_power_down <= 1'b0;
         irq_stat_reg <= 3'h0;
         irq_mask_reg <= 3'h0;
         irq <= 1'b0;
      end else begin
         tone_proc_power_down <= ctrl_reg[0].tone_detect_off && ctrl_reg[1].tone_detect_off;
         irq_stat_reg <= irq_ev | (irq_stat_reg & ~(wr_istat ? wb[2:0] : 3'h0));
         if (wr_imask) irq_mask_reg <= wb[2:0];
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // power down only when both cancellers stop detection
   power_down_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      tone_proc_power_down == $past(ctrl_reg[0].tone_detect_off && ctrl_reg[1].tone_detect_off))
      else $error("tone processor power down wrong");
   // soft reset returns both registers to reset value
   soft_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      soft_rst |=> ctrl_reg[0] == `ECC2_CTRL2_RESET && ctrl_reg[1] == `ECC2_CTRL2_RESET && coeff_clear)
      else $error("soft reset did not preset registers");
   // coefficient clear is a single cycle pulse
   coeff_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      coeff_clear |=> !coeff_clear)
      else $error("coefficient clear longer than one cycle");
   // an event sets its status bit even when a clear lands in the same cycle
   event_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      |irq_ev |=> (irq_stat_reg & $past(irq_ev)) == $past(irq_ev))
      else $error("interrupt event lost");
   // interrupt line follows unmasked status one cycle later
   irq_level_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      irq == $past(|(irq_stat_reg & irq_mask_reg)))
      else $error("interrupt line does not follow status");
   // write response and read data stand until they are taken
   bresp_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   rdata_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
endmodule : ecc2_top

// >>> dv/echo_canceller_control_two_tb.sv
`timescale 1ns/1ps
module echo_canceller_control_two_tb;
   // ********************
   // signals
   // ********************
   logic ref_clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic tone_proc_power_down, coeff_clear, irq;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, data;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, tone_plain_in, tone_rev_in, resp;
   logic [1:0] tone_detect_en, tone_qualified, gated_tone_flag, echo_cancel_off, offset_filter_bypass;
   logic [1:0] nonlinear_proc_off, narrowband_detect_off, send_out_silence, receive_out_silence;
   int fails, checked, clr_seen;

   // ********************
   // design, clock and pulse monitor
   // ********************
   ecc2_top #(.B_MAX_CYC(20)) dut (.ref_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .tone_plain_in, .tone_rev_in, .tone_detect_en,
      .tone_proc_power_down, .tone_qualified, .gated_tone_flag, .echo_cancel_off,
      .offset_filter_bypass, .nonlinear_proc_off, .narrowband_detect_off, .send_out_silence,
      .receive_out_silence, .coeff_clear, .irq);

   // clock of 40 ns period
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // counts coefficient clear pulses
   always @(posedge ref_clk) begin
      if (coeff_clear === 1'b1) clr_seen <= clr_seen + 1;
   end

   // ********************
   // shared tasks
   // ********************
   task complete_run;
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      checked++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
      end
   endtask : chk

   task automatic chb(input logic g, input logic e, input string m);
      chk({31'h0, g}, {31'h0, e}, m);
   endtask : chb

   // one axi4-lite write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      if (s_axi_bvalid !== 1'b1) begin
         fails++;
         complete_run;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   // one axi4-lite read
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      if (s_axi_rvalid !== 1'b1) begin
         fails++;
         complete_run;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd

   // ********************
   // scenarios
   // ********************
   // reset values and an unmapped address
   task automatic t_basic;
      rd(8'h04, data, resp);
      chk(data, 32'h0, "a ctrl2 reset");
      rd(8'h84, data, resp);
      chk(data, 32'h0, "b ctrl2 reset");
      s_axi_wstrb <= 4'he;
      wr(8'h04, 32'hff, resp);
      s_axi_wstrb <= 4'hf;
      rd(8'h04, data, resp);
      chk(data, 32'h0, "lane zero off ignored");
      wr(8'h04, 32'h2b, resp);
      repeat (2) @(posedge ref_clk);
      chk({24'h0, nonlinear_proc_off, narrowband_detect_off, send_out_silence, receive_out_silence}, 32'h55,
         "copied controls");
      wr(8'h40, 32'h5a, resp);
      chk({30'h0, resp}, 32'h2, "unmapped write resp");
      rd(8'h40, data, resp);
      chk({30'h0, resp}, 32'h2, "unmapped read resp");
   endtask : t_basic

   // tone qualification table on canceller a
   task automatic t_tone;
      logic [7:0] cv [5] = '{8'h10, 8'h10, 8'h50, 8'h40, 8'hd0};
      logic [1:0] pv [5] = '{2'b01, 2'b11, 2'b01, 2'b01, 2'b11};
      logic [1:0] ev [5] = '{2'b00, 2'b11, 2'b11, 2'b01, 2'b00};
      for (int i = 0; i < 5; i++) begin
         wr(8'h04, {24'h0, cv[i]}, resp);
         tone_plain_in <= {1'b0, pv[i][0]};
         tone_rev_in <= {1'b0, pv[i][1]};
         repeat (6) @(posedge ref_clk);
         chb(tone_detect_en[0], ~cv[i][7], "detect enable");
         chb(tone_qualified[0], ev[i][0], "qualified");
         chb(gated_tone_flag[0], ev[i][1], "gated flag");
         chb(echo_cancel_off[0], ev[i][1], "cancel off");
         chb(tone_proc_power_down, 1'b0, "power down one off");
         chb(offset_filter_bypass[0], 1'b0, "filter active");
         rd(8'h88, data, resp);
         chb(data[0], ev[i][1], "status gated flag");
      end
      rd(8'h04, data, resp);
      chk(data, 32'hd0, "a ctrl2 readback");
      tone_plain_in <= 2'b00;
      tone_rev_in <= 2'b00;
   endtask : t_tone

   // tone event latched, masked, unmasked and cleared
   task automatic t_irq;
      repeat (6) @(posedge ref_clk);
      rd(8'h8c, data, resp);
      chb(data[0], 1'b1, "tone event latched");
      chb(irq, 1'b0, "irq masked");
      wr(8'h90, 32'h1, resp);
      repeat (2) @(posedge ref_clk);
      chb(irq, 1'b1, "irq unmasked");
      wr(8'h8c, 32'h1, resp);
      repeat (2) @(posedge ref_clk);
      chb(irq, 1'b0, "irq cleared");
      rd(8'h8c, data, resp);
      chb(data[0], 1'b0, "event cleared");
   endtask : t_irq

   // canceller b double write: good pair, mismatch, too early
   task automatic t_bwrite;
      wr(8'h84, 32'h84, resp);
      rd(8'h84, data, resp);
      chk(data, 32'h0, "b single write ignored");
      rd(8'h94, data, resp);
      chb(data[0], 1'b1, "b pending");
      repeat (4) @(posedge ref_clk);
      wr(8'h84, 32'h84, resp);
      repeat (4) @(posedge ref_clk);
      rd(8'h84, data, resp);
      chk(data, 32'h84, "b pair committed");
      chb(tone_proc_power_down, 1'b1, "power down both off");
      chb(offset_filter_bypass[1], 1'b1, "b filter bypassed");
      chb(offset_filter_bypass[0], 1'b0, "a filter active");
      rd(8'h8c, data, resp);
      chb(data[2], 1'b0, "b pair no event");
      wr(8'h84, 32'h11, resp);
      repeat (6) @(posedge ref_clk);
      wr(8'h84, 32'h12, resp);
      rd(8'h84, data, resp);
      chk(data, 32'h84, "b mismatch ignored");
      rd(8'h8c, data, resp);
      chb(data[2], 1'b1, "b mismatch event");
      wr(8'h8c, 32'h4, resp);
      repeat (25) @(posedge ref_clk);
      rd(8'h8c, data, resp);
      chb(data[2], 1'b1, "b timeout event");
      wr(8'h8c, 32'h4, resp);
      wr(8'h84, 32'h13, resp);
      wr(8'h84, 32'h13, resp);
      rd(8'h84, data, resp);
      chk(data, 32'h84, "b early pair ignored");
      rd(8'h8c, data, resp);
      chb(data[2], 1'b1, "b early event");
   endtask : t_bwrite

   // soft reset through control register one
   task automatic t_softrst;
      clr_seen = 0;
      wr(8'h00, 32'h80, resp);
      repeat (3) @(posedge ref_clk);
      chk(clr_seen, 32'h1, "coeff clear pulse");
      rd(8'h04, data, resp);
      chk(data, 32'h0, "a ctrl2 preset");
      rd(8'h84, data, resp);
      chk(data, 32'h0, "b ctrl2 preset");
      rd(8'h00, data, resp);
      chk(data, 32'h0, "reset bit self clear");
      chb(tone_proc_power_down, 1'b0, "power up after preset");
   endtask : t_softrst

   // ********************
   // main sequence
   // ********************
   initial begin
      rst_b = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      tone_plain_in = 2'b00;
      tone_rev_in = 2'b00;
      fails = 0;
      checked = 0;
      clr_seen = 0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge ref_clk);
      t_basic;
      t_tone;
      t_irq;
      t_bwrite;
      t_softrst;
      complete_run;
   end
endmodule : echo_canceller_control_two_tb
